//--- motion_config_map.vh
`ifndef MOTION_CONFIG_MAP_VH
`define MOTION_CONFIG_MAP_VH

// command codes and lengths in words
`define CODE_PROFILE_SHAPE   8'hc3
`define CODE_SERIAL_SELECT   8'hba
`define CODE_ENCODER_FILTER  8'h82
`define CODE_SINGLE_LOOP     8'hf4
`define CODE_SET_MODE        8'h56
`define LEN_PROFILE_SHAPE    2'h2
`define LEN_SERIAL_SELECT    2'h2
`define LEN_ENCODER_FILTER   2'h2
`define LEN_SINGLE_LOOP      2'h1
`define LEN_SET_MODE         2'h3

// profile shape limits and kinds
`define SHAPE_FULL           16'h7fff
`define SHAPE_RESET          16'h0000
`define SHAPE_TRAPEZOID      2'h0
`define SHAPE_PARTIAL        2'h1
`define SHAPE_FULL_S         2'h2

// set-mode selectors
`define SEL_LIMIT_SWITCH     16'h0000
`define SEL_GROUP_ADDR       16'h0001
`define SEL_DC_MOTOR         16'h0002
`define SEL_ANALOG_FB        16'h0003
`define SEL_PULSE_CAPTURE    16'h0007
`define SEL_START_STOP       16'h000f
`define SEL_SPI_NO_DELAY     16'h0014
`define SEL_SPI_DELAY        16'h0015
`define SEL_SPI_WAIT         16'h0016

// protocol kinds on protocol input
`define PROTO_9BIT           2'h0
`define PROTO_8BIT           2'h1

// start/stop speed and capture register numbers
`define REG_START_SPEED      8'h19
`define REG_STOP_SPEED       8'h1a
`define REG_CAPTURE_A        8'hc8
`define REG_CAPTURE_B        8'hc9

// timing at 40 mhz (25 ns)
`define CLOCK_NS             25
`define FILTER_SHORT_NS      100
`define FILTER_ALT_NS        150
`define FILTER_LONG_NS       300
// cycle counts: the ns figures over 25 ns, rounded up, sized for their registers
`define FILTER_SHORT_CYC     4'h4
`define FILTER_ALT_CYC       4'h6
`define FILTER_LONG_CYC      4'hc
`define KEEPALIVE_US         120
`define KEEPALIVE_CYC        18'h012c0

`endif

//--- encoder_glitch_filter.v
`timescale 1ns/1ps
`default_nettype none
`include "motion_config_map.vh"

module encoder_glitch_filter (
	input  wire       clock,
	input  wire       rst_n,
	input  wire       enable,
	input  wire       long_filter,
	input  wire       alt_family,
	input  wire [2:0] raw,
	output wire [2:0] filtered
);
	localparam [3:0] SHORT_CYC = `FILTER_SHORT_CYC;
	localparam [3:0] ALT_CYC   = `FILTER_ALT_CYC;
	localparam [3:0] LONG_CYC  = `FILTER_LONG_CYC;

	wire [3:0] limit = long_filter ? LONG_CYC : (alt_family ? ALT_CYC : SHORT_CYC);

	// each line filtered on its own
	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : line
			reg [3:0] count;
			reg       level;
			assign filtered[i] = level;
			always @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					count <= 4'h0;
					level <= 1'b0;
				end else if (enable) begin
					if (raw[i] == level)
						count <= 4'h0;
					else if (count + 4'h1 >= limit) begin
						level <= raw[i];
						count <= 4'h0;
					end else
						count <= count + 4'h1;
				end
			end
		end
	endgenerate
endmodule // encoder_glitch_filter
`default_nettype wire

//--- pulse_width_capture.v
`timescale 1ns/1ps
`default_nettype none

module pulse_width_capture (
	input  wire        clock,
	input  wire        rst_n,
	input  wire        enable,
	input  wire [3:0]  prescale_exp,
	input  wire        pulse_in,
	output reg  [15:0] width
);
	reg        last;
	reg [15:0] presc;
	reg [15:0] count;
	wire [15:0] presc_mask = (16'h0001 << prescale_exp) - 16'h0001;

	// counts cpu cycles / 2^n from rising to falling edge
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			last  <= 1'b0;
			presc <= 16'h0000;
			count <= 16'h0000;
			width <= 16'h0000;
		end else if (enable) begin
			last <= pulse_in;
			if (pulse_in && !last) begin
				// the rising cycle is the first counted one
				presc <= (presc_mask == 16'h0000) ? 16'h0000 : 16'h0001;
				count <= (presc_mask == 16'h0000) ? 16'h0001 : 16'h0000;
			end else if (pulse_in) begin
				if ((presc & presc_mask) == presc_mask) begin
					presc <= 16'h0000;
					if (count != 16'hffff)
						count <= count + 16'h0001;
				end else
					presc <= presc + 16'h0001;
			end else if (last)
				width <= count;
		end
	end
endmodule // pulse_width_capture
`default_nettype wire

//--- motion_config_command_decoder.v
`timescale 1ns/1ps
`default_nettype none
`include "motion_config_map.vh"

// What this block does
// - shape command 195, two words, signed factor
// - factor 0 trapezoid, to 32766 partial, 32767 full
// - shape change refused while motion runs
// - shape applies to basic moves only
// - command 186 picks RS-232 or RS-485
// - immediate ack goes out on new line
// - command 130 picks encoder glitch filter time
// - filter only on secondary count, lines independent
// - command 244 uses internal encoder feedback
// - single loop during motion flags error
// - single loop copies position into target
// - single loop active after power-up
// - set-mode 86, three words, selector and data
// - selector 0 enables or disables limit switches
// - selector 1 answers group address, 8/9-bit only
// - selector 2 picks stepper or dc motor
// - selector 3 picks analog feedback source
// - capture counts clocks over 2^n prescale
// - captures land in registers 200 and 201
// - start/stop speeds use registers 25, 26
// - selectors 20, 21 set spi clock rate
// - selector 22 waits ticks or input low
module motion_config_command_decoder (
	input  wire        clock,
	input  wire        nrst,
	input  wire        clock_enable,
	input  wire [15:0] cmd_word,
	input  wire        cmd_word_valid,
	input  wire        cmd_first,
	input  wire        cmd_immediate,
	input  wire        motion_running,
	input  wire [1:0]  move_kind_basic,
	input  wire [1:0]  protocol_kind,
	input  wire [31:0] internal_position,
	input  wire        alt_family,
	input  wire [2:0]  encoder_lines,
	input  wire        spi_input_line,
	output reg         ack_pulse,
	output reg         ack_on_rs485,
	output reg         cmd_error,
	output reg  [1:0]  shape_kind,
	output reg  [15:0] shape_factor,
	output reg         shape_active,
	output reg         rs485_select,
	output reg         long_encoder_filter,
	output reg  [2:0]  encoder_filtered,
	output reg  [2:0]  encoder_io_raw,
	output reg         single_loop,
	output reg  [31:0] target_position,
	output reg         target_load,
	output reg         limit_switch_enable,
	output reg         group_addr_enable,
	output reg         dc_motor,
	output reg  [2:0]  analog_feedback_src,
	output reg         capture_enable,
	output reg  [15:0] capture_width_a,
	output reg  [15:0] capture_width_b,
	output reg         start_stop_enable,
	output reg  [7:0]  start_speed_reg,
	output reg  [7:0]  stop_speed_reg,
	output reg  [2:0]  spi_rate,
	output reg         spi_clock_delay,
	output reg         spi_wait_busy,
	output reg         spi_chip_select_pulse
);
	localparam [1:0] ST_IDLE  = 2'h0;
	localparam [1:0] ST_WORD1 = 2'h1;
	localparam [1:0] ST_WORD2 = 2'h2;
	localparam [17:0] KEEPALIVE = `KEEPALIVE_CYC;

	// reset release and pin synchronisers
	reg [1:0] rst_sync;
	wire      rst_n = rst_sync[1];
	reg [2:0] enc_s1;
	reg [2:0] enc_s2;
	reg       spi_s1;
	reg       spi_s2;

	always @(posedge clock or negedge nrst) begin
		if (!nrst)
			rst_sync <= 2'b00;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			enc_s1 <= 3'h0;
			enc_s2 <= 3'h0;
			spi_s1 <= 1'b1;
			spi_s2 <= 1'b1;
		end else if (clock_enable) begin
			enc_s1 <= encoder_lines;
			enc_s2 <= enc_s1;
			spi_s1 <= spi_input_line;
			spi_s2 <= spi_s1;
		end
	end

	wire [2:0] enc_filt;
	encoder_glitch_filter u_filter (
		.clock      (clock),
		.rst_n      (rst_n),
		.enable     (clock_enable),
		.long_filter(long_encoder_filter),
		.alt_family (alt_family),
		.raw        (enc_s2),
		.filtered   (enc_filt)
	);

	wire [15:0] width_a;
	wire [15:0] width_b;
	reg  [3:0]  prescale_exp;
	// io lines double as capture inputs
	pulse_width_capture u_cap_a (
		.clock       (clock),
		.rst_n       (rst_n),
		.enable      (clock_enable),
		.prescale_exp(prescale_exp),
		.pulse_in    (enc_s2[1]),
		.width       (width_a)
	);
	pulse_width_capture u_cap_b (
		.clock       (clock),
		.rst_n       (rst_n),
		.enable      (clock_enable),
		.prescale_exp(prescale_exp),
		.pulse_in    (enc_s2[2]),
		.width       (width_b)
	);

	// command assembly
	reg [1:0]  state;
	reg [7:0]  opcode;
	reg [15:0] selector;
	reg [31:0] wait_ticks;
	reg [17:0] keep_count;
	reg        group_mode;
	// group answering only under the 8/9-bit protocols
	wire       proto_ok = (protocol_kind == `PROTO_8BIT) | (protocol_kind == `PROTO_9BIT);

	function [1:0] classify;
		input [15:0] f;
		begin
			if (f == 16'h0000)
				classify = `SHAPE_TRAPEZOID;
			else if (f == `SHAPE_FULL)
				classify = `SHAPE_FULL_S;
			else if (f[15])
				classify = `SHAPE_TRAPEZOID;
			else
				classify = `SHAPE_PARTIAL;
		end
	endfunction

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state               <= ST_IDLE;
			opcode              <= 8'h00;
			selector            <= 16'h0000;
			ack_pulse           <= 1'b0;
			ack_on_rs485        <= 1'b0;
			cmd_error           <= 1'b0;
			shape_factor        <= `SHAPE_RESET;
			shape_kind          <= `SHAPE_TRAPEZOID;
			rs485_select        <= 1'b0;
			long_encoder_filter <= 1'b0;
			single_loop         <= 1'b1;
			target_position     <= 32'h00000000;
			target_load         <= 1'b0;
			limit_switch_enable <= 1'b0;
			group_addr_enable   <= 1'b0;
			group_mode          <= 1'b0;
			dc_motor            <= 1'b0;
			analog_feedback_src <= 3'h0;
			capture_enable      <= 1'b0;
			prescale_exp        <= 4'h0;
			start_stop_enable   <= 1'b0;
			spi_rate            <= 3'h0;
			spi_clock_delay     <= 1'b0;
			wait_ticks          <= 32'h00000000;
		end else if (clock_enable) begin
			ack_pulse   <= 1'b0;
			cmd_error   <= 1'b0;
			target_load <= 1'b0;
			group_addr_enable <= group_mode & proto_ok;
			if (wait_ticks != 32'h00000000) begin
				if (!spi_s2)
					wait_ticks <= 32'h00000000;
				else
					wait_ticks <= wait_ticks - 32'h00000001;
			end
			if (cmd_word_valid) begin
				if (cmd_first) begin
					opcode <= cmd_word[7:0];
					case (cmd_word[7:0])
						`CODE_SINGLE_LOOP: begin
							state        <= ST_IDLE;
							ack_pulse    <= 1'b1;
							ack_on_rs485 <= rs485_select;
							if (motion_running)
								cmd_error <= 1'b1;
							else begin
								single_loop     <= 1'b1;
								target_position <= internal_position;
								target_load     <= 1'b1;
							end
						end
						`CODE_PROFILE_SHAPE, `CODE_SERIAL_SELECT,
						`CODE_ENCODER_FILTER, `CODE_SET_MODE: state <= ST_WORD1;
						default: state <= ST_IDLE;
					endcase
				end else begin
					case (state)
						ST_WORD1: begin
							if (opcode == `CODE_SET_MODE) begin
								selector <= cmd_word;
								state    <= ST_WORD2;
							end else begin
								state        <= ST_IDLE;
								ack_pulse    <= 1'b1;
								ack_on_rs485 <= rs485_select;
								case (opcode)
									`CODE_PROFILE_SHAPE: begin
										if (motion_running)
											cmd_error <= 1'b1;
										else begin
											shape_factor <= cmd_word;
											shape_kind   <= classify(cmd_word);
										end
									end
									`CODE_SERIAL_SELECT: begin
										rs485_select <= cmd_word[0];
										if (cmd_immediate)
											ack_on_rs485 <= cmd_word[0];
									end
									`CODE_ENCODER_FILTER: long_encoder_filter <= cmd_word[0];
									default: ack_pulse <= 1'b1;
								endcase
							end
						end
						ST_WORD2: begin
							state        <= ST_IDLE;
							ack_pulse    <= 1'b1;
							ack_on_rs485 <= rs485_select;
							case (selector)
								`SEL_LIMIT_SWITCH: limit_switch_enable <= cmd_word[0];
								`SEL_GROUP_ADDR: begin
									group_mode        <= cmd_word[0];
									group_addr_enable <= cmd_word[0] & proto_ok;
								end
								`SEL_DC_MOTOR: dc_motor <= cmd_word[0];
								`SEL_ANALOG_FB: begin
									if (cmd_word <= 16'h0004)
										analog_feedback_src <= cmd_word[2:0];
								end
								`SEL_PULSE_CAPTURE: begin
									capture_enable <= (cmd_word != 16'h0000);
									prescale_exp   <= cmd_word[3:0];
								end
								`SEL_START_STOP: start_stop_enable <= cmd_word[0];
								`SEL_SPI_NO_DELAY, `SEL_SPI_DELAY: begin
									if (cmd_word <= 16'h0006) begin
										spi_rate        <= cmd_word[2:0];
										spi_clock_delay <= selector[0];
									end
								end
								`SEL_SPI_WAIT: wait_ticks <= {16'h0000, cmd_word};
								default: ack_pulse <= 1'b1;
							endcase
						end
						default: state <= ST_IDLE;
					endcase
				end
			end
		end
	end

	// registered status outputs
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			shape_active          <= 1'b0;
			encoder_filtered      <= 3'h0;
			encoder_io_raw        <= 3'h0;
			capture_width_a       <= 16'h0000;
			capture_width_b       <= 16'h0000;
			start_speed_reg       <= 8'h00;
			stop_speed_reg        <= 8'h00;
			spi_wait_busy         <= 1'b0;
			spi_chip_select_pulse <= 1'b0;
			keep_count            <= 18'h00000;
		end else if (clock_enable) begin
			shape_active     <= (move_kind_basic == 2'h1) && (shape_kind != `SHAPE_TRAPEZOID);
			encoder_filtered <= enc_filt;
			encoder_io_raw   <= enc_s2;
			if (capture_enable) begin
				capture_width_a <= width_a;
				capture_width_b <= width_b;
			end else begin
				capture_width_a <= {13'h0000, enc_filt};
				capture_width_b <= 16'h0000;
			end
			start_speed_reg <= start_stop_enable ? `REG_START_SPEED : 8'h00;
			stop_speed_reg  <= start_stop_enable ? `REG_STOP_SPEED : 8'h00;
			spi_wait_busy   <= (wait_ticks != 32'h00000000);
			spi_chip_select_pulse <= 1'b0;
			if (wait_ticks != 32'h00000000) begin
				if (keep_count >= KEEPALIVE - 18'h00001) begin
					keep_count            <= 18'h00000;
					spi_chip_select_pulse <= 1'b1;
				end else
					keep_count <= keep_count + 18'h00001;
			end else
				keep_count <= 18'h00000;
		end
	end

endmodule // motion_config_command_decoder
`default_nettype wire

//--- motion_config_chk.sv
`timescale 1ns/1ps
`default_nettype none
module motion_config_chk (
	input wire logic        clock,
	input wire logic        nrst,
	input wire logic        ack_pulse,
	input wire logic        cmd_error,
	input wire logic [1:0]  shape_kind,
	input wire logic [15:0] shape_factor,
	input wire logic        shape_active,
	input wire logic [1:0]  move_kind_basic,
	input wire logic        target_load,
	input wire logic        single_loop,
	input wire logic        start_stop_enable,
	input wire logic [7:0]  start_speed_reg,
	input wire logic [7:0]  stop_speed_reg,
	input wire logic        spi_chip_select_pulse,
	input wire logic [31:0] internal_position,
	input wire logic [31:0] target_position,
	input wire logic        group_addr_enable,
	input wire logic [1:0]  protocol_kind
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	error_acked_a: assert property (cmd_error |-> ack_pulse) else $error("error without ack");
	trap_kind_a: assert property (shape_factor == 16'h0000 |-> shape_kind == 2'h0) else $error("zero kind");
	partial_kind_a: assert property (shape_factor != 16'h0000 && shape_factor < 16'h7fff
		|-> shape_kind == 2'h1) else $error("partial kind");
	full_kind_a: assert property (shape_factor == 16'h7fff |-> shape_kind == 2'h2) else $error("full kind");
	refused_hold_a: assert property (cmd_error |-> $stable(shape_factor)) else $error("refused changed");
	speed_regs_a: assert property (start_stop_enable && $past(start_stop_enable)
		|-> start_speed_reg == 8'h19 && stop_speed_reg == 8'h1a) else $error("speed regs");
	load_loop_a: assert property (target_load |-> single_loop && target_position == $past(internal_position))
		else $error("load value");
	basic_only_a: assert property (shape_active |-> move_kind_basic == 2'h1 || $past(move_kind_basic) == 2'h1)
		else $error("shape outside basic");
	cs_pulse_a: assert property (spi_chip_select_pulse |=> !spi_chip_select_pulse) else $error("cs long");
	group_proto_a: assert property (group_addr_enable |-> $past(protocol_kind) < 2'h2) else $error("proto");
endmodule // motion_config_chk
bind motion_config_command_decoder motion_config_chk chk (.clock, .nrst, .ack_pulse, .cmd_error, .shape_kind,
	.shape_factor, .shape_active, .move_kind_basic, .target_load, .single_loop, .start_stop_enable,
	.start_speed_reg, .stop_speed_reg, .spi_chip_select_pulse, .internal_position, .target_position,
	.group_addr_enable, .protocol_kind);
`default_nettype wire

//--- host_cmd_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_cmd_model (
	input  wire logic        clock,
	output var  logic [15:0] cmd_word,
	output var  logic        cmd_word_valid,
	output var  logic        cmd_first
);
	initial begin
		cmd_word = 16'h5a5a;
		cmd_word_valid = 1'b0;
		cmd_first = 1'b0;
	end
	task send(input logic [7:0] op, input logic [1:0] n, input logic [15:0] a, input logic [15:0] b);
		begin
			@(posedge clock);
			cmd_word <= {8'h00, op};
			cmd_word_valid <= 1'b1;
			cmd_first <= 1'b1;
			if (n > 2'h1) begin
				@(posedge clock);
				cmd_word <= a;
				cmd_first <= 1'b0;
			end
			if (n > 2'h2) begin
				@(posedge clock);
				cmd_word <= b;
			end
			@(posedge clock);
			cmd_word_valid <= 1'b0;
			cmd_first <= 1'b0;
			// released bus shows no stale word
			cmd_word <= ~cmd_word;
		end
	endtask
endmodule // host_cmd_model
`default_nettype wire

//--- motion_config_command_decoder_bench.sv
`timescale 1ns/1ps
`default_nettype none
module motion_config_command_decoder_bench;
	logic        clock, nrst, cmd_immediate, motion_running, alt_family, spi_input_line;
	logic [1:0]  move_kind_basic, protocol_kind;
	logic [2:0]  encoder_lines;
	logic [31:0] internal_position;
	wire  [15:0] cmd_word, shape_factor, capture_width_a, capture_width_b;
	wire  [7:0]  start_speed_reg, stop_speed_reg;
	wire         cmd_word_valid, cmd_first, ack_pulse, ack_on_rs485, cmd_error, shape_active, rs485_select;
	wire         long_encoder_filter, single_loop, target_load, limit_switch_enable, group_addr_enable;
	wire         dc_motor, capture_enable, start_stop_enable, spi_clock_delay, spi_wait_busy, spi_chip_select_pulse;
	wire  [1:0]  shape_kind;
	wire  [2:0]  encoder_filtered, encoder_io_raw, analog_feedback_src, spi_rate;
	wire  [31:0] target_position;
	int          miscompares = 0;
	int          num_checks = 0;

	motion_config_command_decoder uut (
		.clock, .nrst, .clock_enable(1'b1), .cmd_word, .cmd_word_valid, .cmd_first, .cmd_immediate,
		.motion_running, .move_kind_basic, .protocol_kind, .internal_position, .alt_family,
		.encoder_lines, .spi_input_line, .ack_pulse, .ack_on_rs485, .cmd_error, .shape_kind, .shape_factor,
		.shape_active, .rs485_select, .long_encoder_filter, .encoder_filtered, .encoder_io_raw, .single_loop,
		.target_position, .target_load, .limit_switch_enable, .group_addr_enable, .dc_motor,
		.analog_feedback_src, .capture_enable, .capture_width_a, .capture_width_b, .start_stop_enable,
		.start_speed_reg, .stop_speed_reg, .spi_rate, .spi_clock_delay, .spi_wait_busy, .spi_chip_select_pulse
	);
	host_cmd_model host (.clock, .cmd_word, .cmd_word_valid, .cmd_first);

	task report_and_stop;
		begin
			$display("checks %0d mismatches %0d", num_checks, miscompares);
			if (miscompares == 0 && num_checks > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask

	task check(input logic [47:0] got, input logic [47:0] exp, input string what);
		begin
			num_checks++;
			if (got !== exp) begin
				miscompares++;
				$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
			end
		end
	endtask

	// ack stands in the cycle right after the last word
	task run(input logic [7:0] op, input logic [1:0] n, input logic [15:0] a, input logic [15:0] b, input logic err);
		begin
			host.send(op, n, a, b);
			#1;
			check({ack_pulse, cmd_error}, {1'b1, err}, "ack and error");
		end
	endtask

	task set_mode_cmd(input logic [15:0] sel, input logic [15:0] data, input logic [11:0] exp);
		begin
			run(8'h56, 2'h3, sel, data, 1'b0);
			check({limit_switch_enable, group_addr_enable, dc_motor, analog_feedback_src, capture_enable,
				start_stop_enable, spi_rate, spi_clock_delay}, exp, "mode bits");
		end
	endtask

	task t_shape;
		logic [15:0] f [5];
		logic [1:0]  k [5];
		begin
			f = '{16'h0001, 16'h2a3d, 16'h7ffe, 16'h7fff, 16'h0000};
			k = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h0};
			for (int i = 0; i < 5; i++) begin
				run(8'hc3, 2'h2, f[i], 16'h0000, 1'b0);
				check({shape_kind, shape_factor}, {k[i], f[i]}, "shape");
			end
		end
	endtask

	task t_motion;
		begin
			run(8'hc3, 2'h2, 16'h0100, 16'h0000, 1'b0);
			@(posedge clock);
			motion_running <= 1'b1;
			move_kind_basic <= 2'h1;
			run(8'hc3, 2'h2, 16'h7fff, 16'h0000, 1'b1);
			check(shape_factor, 16'h0100, "shape kept");
			check(shape_active, 1'b1, "basic move");
			run(8'hf4, 2'h1, 16'h0000, 16'h0000, 1'b1);
			@(posedge clock);
			move_kind_basic <= 2'h2;
			repeat (3) @(posedge clock);
			#1 check(shape_active, 1'b0, "other mode");
			@(posedge clock);
			motion_running <= 1'b0;
			move_kind_basic <= 2'h0;
		end
	endtask

	task t_serial;
		begin
			@(posedge clock);
			cmd_immediate <= 1'b1;
			run(8'hba, 2'h2, 16'h0001, 16'h0000, 1'b0);
			check({rs485_select, ack_on_rs485}, 2'h3, "to rs485");
			run(8'hba, 2'h2, 16'h0000, 16'h0000, 1'b0);
			check({rs485_select, ack_on_rs485}, 2'h0, "to rs232");
			@(posedge clock);
			cmd_immediate <= 1'b0;
			run(8'hba, 2'h2, 16'h0001, 16'h0000, 1'b0);
			check({rs485_select, ack_on_rs485}, 2'h2, "late rs485");
			run(8'hba, 2'h2, 16'h0000, 16'h0000, 1'b0);
			check({rs485_select, ack_on_rs485}, 2'h1, "late rs232");
		end
	endtask

	task t_filter;
		logic seen_raw, seen_filt;
		begin
			run(8'h82, 2'h2, 16'h0001, 16'h0000, 1'b0);
			check(long_encoder_filter, 1'b1, "long filter");
			seen_raw = 1'b0;
			seen_filt = 1'b0;
			@(posedge clock);
			encoder_lines <= 3'h2;
			repeat (6) @(posedge clock);
			encoder_lines <= 3'h4;
			repeat (30) begin
				@(posedge clock);
				seen_raw |= encoder_io_raw[1];
				seen_filt |= encoder_filtered[1];
			end
			check({seen_raw, seen_filt, encoder_filtered}, 5'h14, "glitch");
			run(8'h82, 2'h2, 16'h0000, 16'h0000, 1'b0);
			check(long_encoder_filter, 1'b0, "short filter");
		end
	endtask

	task t_single;
		begin
			@(posedge clock);
			internal_position <= 32'h1234abcd;
			run(8'hf4, 2'h1, 16'h0000, 16'h0000, 1'b0);
			check({single_loop, target_position}, {1'b1, 32'h1234abcd}, "target copied");
		end
	endtask

	task t_modes;
		logic [15:0] n;
		begin
			set_mode_cmd(16'h0000, 16'h0001, 12'h800);
			set_mode_cmd(16'h0001, 16'h0001, 12'hc00);
			set_mode_cmd(16'h0002, 16'h0001, 12'he00);
			set_mode_cmd(16'h0003, 16'h0003, 12'hec0);
			set_mode_cmd(16'h0007, 16'h0002, 12'hee0);
			set_mode_cmd(16'h000f, 16'h0001, 12'hef0);
			set_mode_cmd(16'h0014, 16'h0006, 12'hefc);
			set_mode_cmd(16'h0015, 16'h0002, 12'hef5);
			set_mode_cmd(16'h0009, 16'h0001, 12'hef5);
			set_mode_cmd(16'h0000, 16'h0000, 12'h6f5);
			@(posedge clock);
			encoder_lines <= 3'h6;
			repeat (40) @(posedge clock);
			encoder_lines <= 3'h4;
			repeat (6) @(posedge clock);
			#1 check({capture_width_a, capture_width_b, start_speed_reg, stop_speed_reg},
				{16'h000a, 16'h0000, 8'h19, 8'h1a}, "width and speeds");
			@(posedge clock);
			protocol_kind <= 2'h2;
			repeat (2) @(posedge clock);
			#1 check(group_addr_enable, 1'b0, "group off other protocol");
			@(posedge clock);
			protocol_kind <= 2'h0;
			repeat (2) @(posedge clock);
			#1 check(group_addr_enable, 1'b1, "group back on");
			@(posedge clock);
			spi_input_line <= 1'b1;
			run(8'h56, 2'h3, 16'h0016, 16'h7fff, 1'b0);
			n = 16'h0000;
			repeat (4900) begin
				@(posedge clock);
				n += spi_chip_select_pulse;
			end
			check({spi_wait_busy, n}, {1'b1, 16'h0001}, "keepalive");
			spi_input_line <= 1'b0;
			repeat (8) @(posedge clock);
			#1 check(spi_wait_busy, 1'b0, "input low ends wait");
		end
	endtask

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	initial begin
		repeat (20000) @(posedge clock);
		miscompares++;
		report_and_stop;
	end

	initial begin
		{nrst, cmd_immediate, motion_running, alt_family, spi_input_line, move_kind_basic, encoder_lines} = '0;
		protocol_kind = 2'h1;
		internal_position = 32'h0000_0000;
		repeat (6) @(posedge clock);
		nrst <= 1'b1;
		repeat (4) @(posedge clock);
		#1 check({single_loop, shape_kind, rs485_select, long_encoder_filter}, 5'h10, "reset state");
		t_shape;
		t_motion;
		t_serial;
		t_filter;
		t_single;
		t_modes;
		report_and_stop;
	end
endmodule // motion_config_command_decoder_bench
`default_nettype wire
